// ==== hbd_params.svh ====
// Register map, field positions, reset values and timing counts of the event unit
`ifndef HBD_PARAMS_SVH
`define HBD_PARAMS_SVH
`define HBD_OFF_EVENT    8'h00
`define HBD_OFF_MASK     8'h04
`define HBD_OFF_STATUS   8'h08
`define HBD_OFF_CTRL     8'h0C
`define HBD_OFF_MAXFRM   8'h10
`define HBD_OFF_MAXBUF   8'h14
`define HBD_EV_RXB       0
`define HBD_EV_TXB       1
`define HBD_EV_BSY       2
`define HBD_EV_RXF       3
`define HBD_EV_TXE       4
`define HBD_EV_IDL       5
`define HBD_EV_CD        6
`define HBD_EV_CTS       7
`define HBD_CTRL_MODEM   0
`define HBD_RST_EVENT    8'h00
`define HBD_RST_MASK     8'h00
`define HBD_RST_MAXFRM   16'h0100
`define HBD_RST_MAXBUF   16'h0080
`define HBD_RXF_EDGES    2'h2
`define HBD_ABORT_ONES   4'h7
`define HBD_IDLE_ONES    4'hF
`endif

// ==== hbd_pkg.sv ====
// Types shared by the descriptor and event unit
package hbd_pkg;
  typedef struct packed {
    logic        first;
    logic        last;
    logic        lenViol;
    logic        misaligned;
    logic        aborted;
    logic        checkFail;
    logic        lostData;
    logic        carrierLost;
    logic [15:0] len;
  } hbd_rx_stat_t;
  typedef struct packed {
    logic        ready;
    logic        ext;
    logic        wrap;
    logic        intr;
    logic        last;
    logic        appendCheck;
    logic [15:0] len;
  } hbd_tx_desc_t;
  typedef struct packed {
    logic starved;
    logic grantLost;
  } hbd_tx_stat_t;
  typedef enum logic [1:0] {TX_IDLE, TX_FETCH, TX_CLOSING} hbd_tx_state_t;
endpackage

// ==== hbd_event_unit.sv ====
// HDLC channel descriptor status/control handling and event register
// What this block does
// - Receive buffer event only when the descriptor interrupt bit is set.
// - Mark first buffer of a frame; mark last and write length at frame end.
// - Store at most max frame length bytes; report violation at close with true count.
// - Flag misaligned bit count; flag abort on seven consecutive ones in frame.
// - Report check fail, overrun; carrier loss only in modem interface mode.
// - Length written once at close; last holds total frame octets with check bytes.
// - Ready set by software; device clears it after sending or on error.
// - Fetch from internal memory when external bit is 0, else external.
// - After the wrap descriptor continue from the first; wrap within eight.
// - With interrupt bit set raise buffer or error event, else none.
// - Last buffer sends check sequence when append bit is 1, else flag.
// - Record underrun; record grant loss in the currently open descriptor.
// - Eight-bit event register with the documented bit order.
// - Events readable anytime, write one clears, reset to zero.
// - Interrupt request holds while any unmasked event remains.
// - Line change events on clear-to-send, carrier and idle level changes.
// - Frame received event no sooner than two receive clocks after close.
// - Transmit buffer event timing differs for last and other buffers.
// - No-buffer, transmit error and non-final receive buffer events.
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ns
`include "hbd_params.svh"
module hbd_event_unit (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic                       irqReq,
  input  wire logic                  rclk,
  input  wire logic                  rxd,
  input  wire logic                  ctsN,
  input  wire logic                  cdN,
  input  wire logic                  rxStart,
  input  wire logic                  rxByte,
  input  wire logic                  rxClose,
  input  wire logic [2:0]            rxBitRem,
  input  wire logic                  rxCrcBad,
  input  wire logic                  rxOverrun,
  input  wire logic                  rxNoBuf,
  input  wire logic                  rxDescIntr,
  output logic                       rxStoreByte,
  output logic                       rxStatWr,
  output hbd_pkg::hbd_rx_stat_t      rxStat,
  input  hbd_pkg::hbd_tx_desc_t      txDesc,
  input  wire logic                  txFetchAck,
  input  wire logic                  txUnderrun,
  input  wire logic                  txFlag2ndLast,
  output logic                       txFetchReq,
  output logic                       txFetchExt,
  output logic                       txAppendCheck,
  output logic                       txDone,
  output hbd_pkg::hbd_tx_stat_t      txStat,
  output logic      [2:0]            txIdx
);
  logic [7:0]  evt;
  logic [7:0]  mask;
  logic        modemMode;
  logic [15:0] maxFrameLen;
  logic [15:0] maxRxBufLen;
  logic [7:0]  evPulse;
  logic        rxbPulse, rxfPulse, bsyPulse, txbPulse, txePulse;
  logic [7:0]  setv;
  logic [7:0]  evClr;
  logic [2:0]  rclkS;
  logic [2:0]  rxdS;
  logic [2:0]  ctsS;
  logic [2:0]  cdS;
  logic        rclkRise;
  logic [3:0]  onesCnt;
  logic        lineIdle;
  logic        lineIdleQ;
  logic        rxInFrame;
  logic        rxFirst;
  logic        rxLenViol;
  logic        rxLost;
  logic [15:0] rxFrameCnt;
  logic [15:0] rxBufCnt;
  logic        abortNow;
  logic        cdLostNow;
  logic        rxfPend;
  logic [1:0]  rxfEdges;
  hbd_pkg::hbd_tx_state_t txState;
  hbd_pkg::hbd_tx_desc_t  txCur;
  logic [15:0] txCnt;
  logic        ctsLostNow;
  logic        txErr;
  logic        apbWrite;

  // Link pins: two flops before use, third stage for edges
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rclkS <= 3'h0;
      rxdS  <= 3'h7;
      ctsS  <= 3'h7;
      cdS   <= 3'h7;
    end
    else if (ce)
    begin
      rclkS <= {rclkS[1:0], rclk};
      rxdS  <= {rxdS[1:0], rxd};
      ctsS  <= {ctsS[1:0], ctsN};
      cdS   <= {cdS[1:0], cdN};
    end
  end
  assign rclkRise = rclkS[1] && !rclkS[2];

  // Run of ones on the receive line, counted per receive clock
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      onesCnt   <= 4'h0;
      lineIdleQ <= 1'b0;
    end
    else if (ce)
    begin
      lineIdleQ <= lineIdle;
      if (rclkRise)
        onesCnt <= !rxdS[1] ? 4'h0 : (onesCnt == `HBD_IDLE_ONES) ? onesCnt : onesCnt + 4'h1;
    end
  end
  assign lineIdle   = (onesCnt == `HBD_IDLE_ONES);
  // Seventh one arrives on this edge
  assign abortNow   = rxInFrame && rclkRise && rxdS[1] && (onesCnt == `HBD_ABORT_ONES - 4'h1);
  // Carrier is active low; loss only matters in modem mode
  assign cdLostNow  = rxInFrame && modemMode && cdS[1] && !cdS[2];

  // Receive descriptor status
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rxInFrame   <= 1'b0;
      rxFirst     <= 1'b0;
      rxLenViol   <= 1'b0;
      rxLost      <= 1'b0;
      rxFrameCnt  <= 16'h0000;
      rxBufCnt    <= 16'h0000;
      rxStoreByte <= 1'b0;
      rxStatWr    <= 1'b0;
      rxStat      <= '0;
      rxfPend     <= 1'b0;
      rxfEdges    <= 2'h0;
      rxbPulse    <= 1'b0;
      rxfPulse    <= 1'b0;
      bsyPulse    <= 1'b0;
    end
    else if (ce)
    begin
      rxStoreByte <= 1'b0;
      rxStatWr    <= 1'b0;
      rxbPulse    <= 1'b0;
      rxfPulse    <= 1'b0;
      bsyPulse    <= rxNoBuf;
      if (rxfPend && rclkRise)
      begin
        rxfEdges <= rxfEdges + 2'h1;
        if (rxfEdges + 2'h1 == `HBD_RXF_EDGES)
        begin
          rxfPend <= 1'b0;
          rxfPulse <= 1'b1;
        end
      end
      if (rxStart)
      begin
        rxInFrame  <= 1'b1;
        rxFirst    <= 1'b1;
        rxLenViol  <= 1'b0;
        rxLost     <= 1'b0;
        rxFrameCnt <= 16'h0000;
        rxBufCnt   <= 16'h0000;
      end
      else if (rxInFrame && (cdLostNow || abortNow || rxClose))
      begin
        // Carrier loss outranks abort; abort skips check and alignment status
        rxInFrame          <= 1'b0;
        rxStatWr           <= 1'b1;
        rxStat.first       <= rxFirst;
        rxStat.last        <= 1'b1;
        rxStat.len         <= rxFrameCnt;
        rxStat.carrierLost <= cdLostNow;
        rxStat.aborted     <= !cdLostNow && abortNow;
        rxStat.lostData    <= rxLost || rxOverrun;
        rxStat.lenViol     <= !cdLostNow && !abortNow && rxLenViol;
        rxStat.misaligned  <= !cdLostNow && !abortNow && (rxBitRem != 3'h0);
        rxStat.checkFail   <= !cdLostNow && !abortNow && rxCrcBad;
        rxfPend            <= 1'b1;
        rxfEdges           <= 2'h0;
      end
      else if (rxInFrame)
      begin
        if (rxOverrun)
          rxLost <= 1'b1;
        if (rxByte)
        begin
          rxFrameCnt <= rxFrameCnt + 16'h0001;
          if (rxFrameCnt < maxFrameLen)
          begin
            rxStoreByte <= 1'b1;
            if (rxBufCnt + 16'h0001 == maxRxBufLen)
            begin
              // Buffer full mid-frame: close it as a non-final buffer
              rxBufCnt   <= 16'h0000;
              rxFirst    <= 1'b0;
              rxStatWr   <= 1'b1;
              rxStat     <= '0;
              rxStat.first <= rxFirst;
              rxStat.len <= rxBufCnt + 16'h0001;
              rxbPulse   <= rxDescIntr;
            end
            else
              rxBufCnt <= rxBufCnt + 16'h0001;
          end
          else
            rxLenViol <= 1'b1;
        end
      end
    end
  end

  // Transmit descriptor handling
  assign ctsLostNow = (txState != hbd_pkg::TX_IDLE) && ctsS[1] && !ctsS[2];
  assign txErr      = (txState != hbd_pkg::TX_IDLE) && (txUnderrun || ctsLostNow);
  assign txFetchReq = (txState == hbd_pkg::TX_FETCH);
  assign txFetchExt = txCur.ext;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      txState       <= hbd_pkg::TX_IDLE;
      txCur         <= '0;
      txCnt         <= 16'h0000;
      txIdx         <= 3'h0;
      txDone        <= 1'b0;
      txStat        <= '0;
      txAppendCheck <= 1'b0;
      txbPulse      <= 1'b0;
      txePulse      <= 1'b0;
    end
    else if (ce)
    begin
      txDone   <= 1'b0;
      txbPulse <= 1'b0;
      txePulse <= 1'b0;
      if (txErr)
      begin
        // Ready is handed back on error; status lands in the open descriptor
        txState        <= hbd_pkg::TX_IDLE;
        txDone         <= 1'b1;
        txStat.starved   <= txUnderrun;
        txStat.grantLost <= ctsLostNow;
        txAppendCheck  <= 1'b0;
        txePulse       <= txCur.intr;
        txIdx          <= txCur.wrap ? 3'h0 : txIdx + 3'h1;
      end
      else
      begin
        unique case (txState)
          hbd_pkg::TX_IDLE:
          begin
            if (txDesc.ready)
            begin
              // Latched copy; length is only read, never written back
              txCur   <= txDesc;
              txCnt   <= 16'h0000;
              txState <= hbd_pkg::TX_FETCH;
            end
          end
          hbd_pkg::TX_FETCH:
          begin
            if (txFetchAck)
            begin
              txCnt <= txCnt + 16'h0001;
              if (txCnt + 16'h0001 >= txCur.len)
              begin
                if (txCur.last)
                begin
                  txAppendCheck <= txCur.appendCheck;
                  txState       <= hbd_pkg::TX_CLOSING;
                end
                else
                begin
                  // Non-final buffer is done once its last byte is queued
                  txState <= hbd_pkg::TX_IDLE;
                  txDone  <= 1'b1;
                  txStat  <= '0;
                  txbPulse <= txCur.intr;
                  txIdx   <= txCur.wrap ? 3'h0 : txIdx + 3'h1;
                end
              end
            end
          end
          hbd_pkg::TX_CLOSING:
          begin
            if (txFlag2ndLast)
            begin
              txState       <= hbd_pkg::TX_IDLE;
              txDone        <= 1'b1;
              txStat        <= '0;
              txAppendCheck <= 1'b0;
              txbPulse      <= txCur.intr;
              txIdx         <= txCur.wrap ? 3'h0 : txIdx + 3'h1;
            end
          end
        endcase
      end
    end
  end

  // Line level changes seen after synchronisation; one driver, in event register order
  assign evPulse = {ctsS[1] ^ ctsS[2], cdS[1] ^ cdS[2], lineIdle ^ lineIdleQ,
                    txePulse, rxfPulse, bsyPulse, txbPulse, rxbPulse};
  assign setv = evPulse;

  // APB slave, zero wait states
  assign pready   = 1'b1;
  assign apbWrite = psel && penable && pwrite;
  assign pslverr  = psel && penable && !(paddr == `HBD_OFF_EVENT || paddr == `HBD_OFF_MASK
                    || paddr == `HBD_OFF_STATUS || paddr == `HBD_OFF_CTRL
                    || paddr == `HBD_OFF_MAXFRM || paddr == `HBD_OFF_MAXBUF);
  assign evClr    = (apbWrite && paddr == `HBD_OFF_EVENT) ? pwdata[7:0] : 8'h00;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      evt <= `HBD_RST_EVENT;
    else if (ce)
      evt <= (evt & ~evClr) | setv;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mask        <= `HBD_RST_MASK;
      modemMode   <= 1'b0;
      maxFrameLen <= `HBD_RST_MAXFRM;
      maxRxBufLen <= `HBD_RST_MAXBUF;
    end
    else if (ce && apbWrite)
    begin
      if (paddr == `HBD_OFF_MASK)
        mask <= pwdata[7:0];
      if (paddr == `HBD_OFF_CTRL)
        modemMode <= pwdata[`HBD_CTRL_MODEM];
      if (paddr == `HBD_OFF_MAXFRM)
        maxFrameLen <= pwdata[15:0];
      if (paddr == `HBD_OFF_MAXBUF)
        maxRxBufLen <= pwdata[15:0];
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prdata <= 32'h00000000;
    else if (ce && psel && !penable)
    begin
      unique case (paddr)
        `HBD_OFF_EVENT:  prdata <= {24'h000000, evt};
        `HBD_OFF_MASK:   prdata <= {24'h000000, mask};
        `HBD_OFF_STATUS: prdata <= {29'h00000000, lineIdle, cdS[1], ctsS[1]};
        `HBD_OFF_CTRL:   prdata <= {31'h00000000, modemMode};
        `HBD_OFF_MAXFRM: prdata <= {16'h0000, maxFrameLen};
        `HBD_OFF_MAXBUF: prdata <= {16'h0000, maxRxBufLen};
        default:         prdata <= 32'h00000000;
      endcase
    end
  end

  assign irqReq = |(evt & mask);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_evt_w1c_clear: assert property (ce && evClr != 8'h00 && setv == 8'h00 |=> (evt & $past(evClr)) == 8'h00) else $error("event bit not cleared");
  a_evt_set_wins: assert property (ce && setv != 8'h00 |=> (evt & $past(setv)) == $past(setv)) else $error("event set lost");
  a_irq_hold_req: assert property (ce && irqReq && evClr == 8'h00
    && !(apbWrite && paddr == `HBD_OFF_MASK) |=> irqReq) else $error("interrupt request dropped");
  a_rxb_intr_gate: assert property (ce && $rose(evt[`HBD_EV_RXB]) |-> $past(rxDescIntr)) else $error("buffer event without interrupt bit");
  a_rx_store_limit: assert property (rxStoreByte |-> rxFrameCnt <= maxFrameLen) else $error("byte stored beyond max");
  a_rx_abort_seen: assert property (ce && abortNow && !cdLostNow |=> rxStatWr && rxStat.aborted && rxStat.last) else $error("abort not reported");
  a_rxf_not_early: assert property (ce && rxStatWr && rxStat.last |-> !evPulse[`HBD_EV_RXF] ##1 !evPulse[`HBD_EV_RXF]) else $error("frame event too early");
  a_tx_wrap_first: assert property (ce && txState != hbd_pkg::TX_IDLE && txCur.wrap && (txErr || (txState == hbd_pkg::TX_CLOSING && txFlag2ndLast)) |=> txIdx == 3'h0) else $error("wrap not honoured");
  a_tx_event_gate: assert property (txDone |-> (evPulse[`HBD_EV_TXB] || evPulse[`HBD_EV_TXE]) == txCur.intr) else $error("transmit event mismatch");
  a_tx_txb_timing: assert property (ce && evPulse[`HBD_EV_TXB] && txCur.last |-> $past(txFlag2ndLast)) else $error("last buffer event too early");

  c_rx_frame_done: cover property (rxStatWr && rxStat.last && !rxStat.first);
  c_rx_abort: cover property (rxStatWr && rxStat.aborted);
  c_tx_last_done: cover property (txDone && txCur.last && !txStat.starved);
  c_tx_error: cover property (txDone && txStat.grantLost);
endmodule

// ==== hbd_line_model.sv ====
// Remote station model: receive line clock, receive data and modem status lines
`timescale 1ns/1ns
module hbd_line_model (
  output logic rclk,
  output logic rxd,
  output logic ctsN,
  output logic cdN
);
  initial
  begin
    rclk = 1'b0;
    rxd  = 1'b1;
    ctsN = 1'b1;
    cdN  = 1'b1;
  end
  // Clock stands low between frames; data line shows the inverse of the last bit
  task automatic sendBits(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      rxd <= bits[i];
      #160 rclk <= 1'b1;
      #160 rclk <= 1'b0;
    end
    rxd <= ~rxd;
  endtask
  // Called on a clock edge, so lines change after the design has sampled them
  task automatic setLines(input logic cts, input logic cd);
    ctsN <= cts;
    cdN  <= cd;
  endtask
endmodule

// ==== tb.sv ====
// Self-checking bench of the descriptor status and event unit
`timescale 1ns/1ns
`include "hbd_params.svh"
module tb;
  localparam logic [7:0] EV = `HBD_OFF_EVENT;
  logic                  clk, rst, psel, penable, pwrite, pready, pslverr, irqReq;
  logic [7:0]            paddr;
  logic [31:0]           pwdata, prdata, rd;
  logic                  rclk, rxd, ctsN, cdN, rxStart, rxByte, rxClose, rxCrcBad;
  logic                  rxOverrun, rxNoBuf, rxDescIntr, rxStoreByte, rxStatWr, er;
  logic [2:0]            rxBitRem, txIdx, idx;
  logic                  txFetchAck, txUnderrun, txFlag2ndLast, txFetchReq, txFetchExt;
  logic                  txAppendCheck, txDone;
  hbd_pkg::hbd_rx_stat_t rxStat;
  hbd_pkg::hbd_rx_stat_t rxQ[$];
  hbd_pkg::hbd_tx_desc_t txDesc, d, nd;
  hbd_pkg::hbd_tx_stat_t txStat;
  int                    failCount, nTests, cyc, seed, storeCnt, doneCnt, dc, n;
  logic [7:0]            errFlags[3] = '{8'hD0, 8'hC4, 8'hC2};

  // Descriptor memory: the done write-back clears ready in the same cycle
  assign txDesc = {d.ready & ~txDone, d[20:0]};

  hbd_event_unit u_hbd_event_unit (
    .clk(clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irqReq(irqReq), .rclk(rclk), .rxd(rxd), .ctsN(ctsN), .cdN(cdN), .rxStart(rxStart),
    .rxByte(rxByte), .rxClose(rxClose), .rxBitRem(rxBitRem), .rxCrcBad(rxCrcBad),
    .rxOverrun(rxOverrun), .rxNoBuf(rxNoBuf), .rxDescIntr(rxDescIntr),
    .rxStoreByte(rxStoreByte), .rxStatWr(rxStatWr), .rxStat(rxStat), .txDesc(txDesc),
    .txFetchAck(txFetchAck), .txUnderrun(txUnderrun), .txFlag2ndLast(txFlag2ndLast),
    .txFetchReq(txFetchReq), .txFetchExt(txFetchExt), .txAppendCheck(txAppendCheck),
    .txDone(txDone), .txStat(txStat), .txIdx(txIdx)
  );
  hbd_line_model u_hbd_line_model (.rclk(rclk), .rxd(rxd), .ctsN(ctsN), .cdN(cdN));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task conclude();
    $display("checks %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (rxStoreByte === 1'b1)
      storeCnt++;
    if (rxStatWr === 1'b1)
      rxQ.push_back(rxStat);
    if (txDone === 1'b1)
    begin
      doneCnt++;
      d.ready <= 1'b0;
    end
    if (cyc == 20000)
    begin
      failCount++;
      conclude();
    end
  end

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      failCount++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [23:0] mkRx(input logic [7:0] f, input logic [15:0] len);
    return {f, len};
  endfunction

  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdChk(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask

  task irqChk(input logic e);
    @(posedge clk);
    check("interrupt request", irqReq, e);
  endtask

  task clrEv();
    repeat (4) @(posedge clk);
    apb(1'b1, EV, 32'hFF);
  endtask

  task startFrame();
    storeCnt = 0;
    rxStart <= 1'b1;
    @(posedge clk);
    rxStart <= 1'b0;
  endtask

  task rxFrame(input int len, input logic [2:0] rem, input logic bad, input logic ov);
    startFrame();
    for (int i = 0; i < len; i++)
    begin
      rxByte    <= 1'b1;
      rxOverrun <= ov && i == 0;
      @(posedge clk);
      rxByte    <= 1'b0;
      rxOverrun <= 1'b0;
      @(posedge clk);
    end
    rxBitRem <= rem;
    rxCrcBad <= bad;
    rxClose  <= 1'b1;
    @(posedge clk);
    rxClose <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Closing flag gives the receiver the line clock edges it waits for
  task flagOut();
    u_hbd_line_model.sendBits(16'h007E, 8);
    repeat (3) @(posedge clk);
  endtask

  task rxChk(input logic [23:0] e, input logic full);
    hbd_pkg::hbd_rx_stat_t got;
    got = (rxQ.size() > 0) ? rxQ.pop_front() : 'x;
    check("rx status", full ? got : got[23:16], full ? e : e[23:16]);
  endtask

  initial
  begin
    seed = 59412;
    rst  = 1'b1;
    {psel, penable, pwrite, rxStart, rxByte, rxClose, rxCrcBad, rxOverrun} = '0;
    {rxNoBuf, txFetchAck, txUnderrun, txFlag2ndLast} = '0;
    {paddr, pwdata, rxBitRem} = '0;
    rxDescIntr = 1'b1;
    d = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdChk(EV, 32'h0, "event reset");
    rdChk(`HBD_OFF_MASK, 32'h0, "mask reset");
    rdChk(`HBD_OFF_MAXBUF, 32'h80, "buffer limit reset");
    rdChk(8'hFC, 32'h0, "unmapped data");
    check("unmapped error", er, 1'b1);
    u_hbd_line_model.setLines(1'b0, 1'b0);
    rxNoBuf <= 1'b1;
    @(posedge clk);
    rxNoBuf <= 1'b0;
    u_hbd_line_model.sendBits(16'hFFFF, 16);
    repeat (4) @(posedge clk);
    rdChk(EV, 32'hE4, "line events");
    rdChk(`HBD_OFF_STATUS, 32'h4, "line status");
    apb(1'b1, `HBD_OFF_MASK, 32'h04);
    irqChk(1'b1);
    apb(1'b1, EV, 32'h20);
    rdChk(EV, 32'hC4, "partial clear");
    irqChk(1'b1);
    apb(1'b1, EV, 32'h04);
    irqChk(1'b0);
    u_hbd_line_model.setLines(1'b0, 1'b0);
    flagOut();
    clrEv();
    rdChk(EV, 32'h0, "all cleared");
    // Frames spanning two buffers, with and without the interrupt bit
    apb(1'b1, `HBD_OFF_MAXBUF, 32'h4);
    for (int k = 0; k < 3; k++)
    begin
      n = 5 + $unsigned($random(seed)) % 3;
      rxDescIntr <= k != 1;
      rxFrame(n, 3'h0, 1'b0, 1'b0);
      rdChk(EV, {31'h0, k != 1}, "buffer event");
      flagOut();
      rdChk(EV, {28'h0, 1'b1, 2'b0, k != 1}, "frame event");
      rxChk(mkRx(8'h80, 16'h4), 1'b1);
      rxChk(mkRx(8'h40, 16'(n)), 1'b1);
      check("stored bytes", storeCnt, n);
      clrEv();
    end
    apb(1'b1, `HBD_OFF_MAXBUF, 32'h10);
    for (int k = 0; k < 3; k++)
    begin
      rxFrame(3, k == 0 ? 3'h3 : 3'h0, k == 1, k == 2);
      flagOut();
      rxChk(mkRx(errFlags[k], 16'h3), 1'b1);
      clrEv();
    end
    apb(1'b1, `HBD_OFF_MAXFRM, 32'h5);
    rxFrame(7, 3'h0, 1'b0, 1'b0);
    flagOut();
    check("stored bytes", storeCnt, 5);
    rxChk(mkRx(8'hE0, 16'h7), 1'b1);
    rdChk(EV, 32'h08, "frame only");
    apb(1'b1, `HBD_OFF_MAXFRM, 32'h100);
    clrEv();
    startFrame();
    u_hbd_line_model.sendBits(16'h01FE, 9);
    repeat (4) @(posedge clk);
    rxChk(mkRx(8'hC8, 16'h0), 1'b0);
    flagOut();
    clrEv();
    apb(1'b1, `HBD_OFF_CTRL, 32'h1);
    startFrame();
    u_hbd_line_model.setLines(1'b0, 1'b1);
    repeat (6) @(posedge clk);
    rxChk(mkRx(8'hC1, 16'h0), 1'b0);
    flagOut();
    rdChk(EV, 32'h48, "carrier events");
    u_hbd_line_model.setLines(1'b0, 1'b0);
    apb(1'b1, `HBD_OFF_CTRL, 32'h0);
    clrEv();
    // Transmit: underrun on pass 4, grant loss on pass 7, wrap at index 5
    idx = 3'h0;
    for (int k = 0; k < 12; k++)
    begin
      nd       = hbd_pkg::hbd_tx_desc_t'(22'($random(seed)));
      nd.ready = 1'b1;
      nd.wrap  = idx == 3'h5;
      nd.len   = 16'h1 + 16'($unsigned($random(seed)) % 4);
      if (k == 4 || k == 7)
      begin
        nd.len  = 16'h4;
        nd.last = 1'b0;
      end
      dc = doneCnt;
      d <= nd;
      repeat (2) @(posedge clk);
      check("fetch request", txFetchReq, 1'b1);
      check("fetch source", txFetchExt, nd.ext);
      for (int i = 0; i < 4; i++)
        if (i < nd.len && (i == 0 || (k != 4 && k != 7)))
        begin
          txFetchAck <= 1'b1;
          txUnderrun <= k == 4;
          @(posedge clk);
          txFetchAck <= 1'b0;
          txUnderrun <= 1'b0;
          if (k == 7)
            u_hbd_line_model.setLines(1'b1, 1'b0);
          @(posedge clk);
        end
      if (nd.last)
      begin
        repeat (3) @(posedge clk);
        check("early done", doneCnt, dc);
        check("append check", txAppendCheck, nd.appendCheck);
        txFlag2ndLast <= 1'b1;
        @(posedge clk);
        txFlag2ndLast <= 1'b0;
      end
      for (int t = 0; t < 12 && doneCnt == dc; t++)
        @(posedge clk);
      check("done count", doneCnt, dc + 1);
      check("tx status", txStat, {k == 4, k == 7});
      idx = nd.wrap ? 3'h0 : idx + 3'h1;
      check("index", txIdx, idx);
      rdChk(EV, {k == 7, 2'b0, nd.intr && (k == 4 || k == 7), 2'b0,
                 nd.intr && k != 4 && k != 7, 1'b0}, "tx events");
      u_hbd_line_model.setLines(1'b0, 1'b0);
      clrEv();
    end
    conclude();
  end
endmodule
